// ===== core/spfp_core.sv
/*
 * Error, low-power and flag logic of a serial master/slave link with its shifter.
 * Assumes CPU access strobes are one-cycle pulses on clk and baud_tick comes from a divider.
 */
`timescale 1ns/1ps
module spfp_core (
    input  wire logic                     clk,
    input  wire logic                     reset,
    input  wire logic                     baud_tick,
    input  wire logic                     doze_mode,
    input  wire logic                     stop_mode,
    input  wire logic                     doze_stop_bit,
    input  wire logic                     ctrl_one_wr,
    input  wire spfp_pkg::spfp_ctrl_one_t ctrl_one_wdata,
    input  wire logic                     dir_wr,
    input  wire logic [3:0]               dir_wdata,
    input  wire logic                     data_wr,
    input  wire logic [7:0]               data_wdata,
    input  wire logic                     data_rd,
    input  wire logic                     status_rd,
    input  wire spfp_pkg::spfp_pins_t     pins_in,
    output spfp_pkg::spfp_pin_drive_t     pin_drive,
    output spfp_pkg::spfp_ctrl_one_t      serial_control_one,
    output logic [3:0]                    port_direction_bits,
    output spfp_pkg::spfp_status_t        serial_status_reg,
    output logic [7:0]                    serial_data_reg,
    output logic                          irq
);
    import spfp_pkg::*;

    spfp_pins_t              pins_sync;
    spfp_ctrl_one_t          ctrl_reg;
    logic [3:0]              dir_reg;
    logic                    fault_reg;
    logic                    done_reg;
    logic                    coll_reg;
    logic                    fault_armed_reg;
    logic                    data_armed_reg;
    logic [7:0]              rx_reg;
    logic [7:0]              shift_reg;
    logic                    out_bit_reg;
    logic [EDGE_CNT_W-1:0]   edge_cnt_reg;
    logic                    active_reg;
    logic                    started_reg;
    logic                    sck_out_reg;
    logic                    sck_prev_reg;
    logic [1:0]              tail_cnt_reg;
    logic                    tail_ok_reg;
    logic                    irq_reg;

    spfp_sync #(.WIDTH($bits(spfp_pins_t))) u_sync (
        .clk   (clk),
        .reset (reset),
        .din   (pins_in),
        .dout  (pins_sync)
    );

    wire logic enabled     = ctrl_reg.system_enable_bit;
    wire logic is_master   = ctrl_reg.master_select_bit;
    wire logic cpha        = ctrl_reg.clk_phase;
    wire logic ss_low      = ~pins_sync.ss_n;
    // Stop mode is treated exactly like doze with doze-stop set.
    wire logic low_power   = stop_mode | (doze_mode & doze_stop_bit);
    wire logic run         = enabled & ~low_power;
    // Slave edges are taken even in low power so the slave stays in step.
    wire logic slave_edge  = enabled & ~is_master & ss_low & (pins_sync.sck ^ sck_prev_reg);
    wire logic m_tick      = run & is_master & active_reg & baud_tick;
    wire logic m_edge      = m_tick & started_reg;
    wire logic edge_any    = slave_edge | m_edge;
    wire logic sck_now     = is_master ? ~sck_out_reg : pins_sync.sck;
    wire logic leading     = sck_now ^ ctrl_reg.clk_polarity;
    wire logic sample_edge = edge_any & (leading ^ cpha);
    wire logic shift_edge  = edge_any & ~(leading ^ cpha);
    wire logic rx_in       = (is_master ^ ctrl_reg.bidir_mode) ? pins_sync.miso : pins_sync.mosi;
    wire logic last_edge   = edge_any & (edge_cnt_reg == EDGE_CNT_W'(EDGES_PER_BYTE - 1));
    wire logic [7:0] rx_word = sample_edge ? {shift_reg[6:0], rx_in} : shift_reg;
    wire logic slave_busy  = ss_low & (~cpha | ~tail_ok_reg);
    wire logic busy        = enabled & (is_master ? active_reg : slave_busy);
    wire logic wr_collide  = data_wr & busy;
    wire logic wr_ok       = data_wr & ~busy;
    wire logic data_access = data_wr | data_rd;
    wire logic done_clr    = data_access & data_armed_reg;
    wire logic fault_clr   = ctrl_one_wr & fault_armed_reg;
    // A select pin set as output (plain or automatic) never reports a fault.
    wire logic fault_det   = enabled & is_master & ~dir_reg[DIR_SS] & ss_low;
    wire logic done_load   = last_edge & ~low_power & (~done_reg | done_clr);
    wire logic master_drv  = enabled & is_master;

    // Control and direction bits; a fault overrides a same-cycle write.
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_reg <= CTRL_ONE_RESET;
            dir_reg  <= DIR_RESET;
        end else if (fault_det) begin
            ctrl_reg.system_enable_bit <= 1'b0;
            ctrl_reg.master_select_bit <= 1'b0;
            dir_reg[DIR_SCK]           <= 1'b0;
            dir_reg[DIR_MOSI]          <= 1'b0;
            dir_reg[DIR_MISO]          <= dir_reg[DIR_MISO] & ctrl_reg.bidir_mode;
        end else begin
            if (ctrl_one_wr) begin
                ctrl_reg <= ctrl_one_wdata;
            end
            if (dir_wr) begin
                dir_reg <= dir_wdata;
            end
        end
    end

    // Status flags; a set in the same cycle as its clear wins.
    always_ff @(posedge clk) begin
        if (reset) begin
            fault_reg       <= 1'b0;
            done_reg        <= 1'b0;
            coll_reg        <= 1'b0;
            fault_armed_reg <= 1'b0;
            data_armed_reg  <= 1'b0;
        end else begin
            fault_reg <= fault_det | (fault_reg & ~fault_clr);
            done_reg  <= done_load | (done_reg & ~done_clr);
            coll_reg  <= wr_collide | (coll_reg & ~done_clr);
            if (status_rd) begin
                fault_armed_reg <= fault_reg;
                data_armed_reg  <= done_reg | coll_reg;
            end else begin
                fault_armed_reg <= fault_armed_reg & ~fault_clr;
                data_armed_reg  <= data_armed_reg & ~done_clr;
            end
        end
    end

    // Received data only enters the data register while the done flag is free.
    always_ff @(posedge clk) begin
        if (reset) begin
            rx_reg <= DATA_RESET;
        end else if (done_load) begin
            rx_reg <= rx_word;
        end
    end

    // Shifter; reset clears it, and between writes it holds what it last received.
    always_ff @(posedge clk) begin
        if (reset) begin
            shift_reg   <= DATA_RESET;
            out_bit_reg <= 1'b0;
        end else if (wr_ok) begin
            shift_reg   <= data_wdata;
            out_bit_reg <= data_wdata[7];
        end else begin
            if (sample_edge) begin
                shift_reg <= {shift_reg[6:0], rx_in};
            end
            if (shift_edge | (~is_master & ~ss_low)) begin
                out_bit_reg <= shift_reg[7];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset || !enabled || (!is_master && !ss_low)) begin
            edge_cnt_reg <= '0;
        end else if (edge_any) begin
            edge_cnt_reg <= last_edge ? '0 : edge_cnt_reg + 1'b1;
        end
    end

    // Master sequencer; ticks are ignored in low power, so it freezes in place.
    always_ff @(posedge clk) begin
        if (reset || !master_drv) begin
            active_reg  <= 1'b0;
            started_reg <= 1'b0;
        end else if (wr_ok) begin
            active_reg  <= 1'b1;
            started_reg <= 1'b0;
        end else if (m_tick && !started_reg) begin
            started_reg <= 1'b1;
        end else if (m_edge && last_edge) begin
            active_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            sck_out_reg  <= 1'b0;
            sck_prev_reg <= 1'b0;
        end else begin
            sck_prev_reg <= pins_sync.sck;
            if (!active_reg) begin
                sck_out_reg <= ctrl_reg.clk_polarity;
            end else if (m_edge) begin
                sck_out_reg <= ~sck_out_reg;
            end
        end
    end

    // Two-clock guard after a phase 1 slave byte, since an early write can race the last bit.
    always_ff @(posedge clk) begin
        if (reset || !ss_low) begin
            tail_cnt_reg <= 2'h0;
            tail_ok_reg  <= 1'b1;
        end else if (slave_edge && last_edge) begin
            tail_cnt_reg <= 2'(TAIL_GUARD_CLKS);
            tail_ok_reg  <= 1'b0;
        end else if (slave_edge) begin
            tail_ok_reg <= 1'b0;
        end else if (tail_cnt_reg != 2'h0) begin
            tail_cnt_reg <= tail_cnt_reg - 2'h1;
            tail_ok_reg  <= (tail_cnt_reg == 2'h1);
        end
    end

    // The collision flag is left out of the interrupt on purpose.
    always_ff @(posedge clk) begin
        if (reset) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= ctrl_reg.serial_irq_enable & (done_reg | fault_reg);
        end
    end

    assign pin_drive.sck       = sck_out_reg;
    assign pin_drive.sck_oe_n  = ~(master_drv & dir_reg[DIR_SCK]);
    assign pin_drive.mosi      = out_bit_reg;
    assign pin_drive.mosi_oe_n = ~(master_drv & dir_reg[DIR_MOSI]);
    assign pin_drive.miso      = out_bit_reg;
    assign pin_drive.miso_oe_n = ~(enabled & ~is_master & dir_reg[DIR_MISO] & ss_low);
    assign pin_drive.ss_n      = ~active_reg;
    assign pin_drive.ss_oe_n   = ~(master_drv & ctrl_reg.ss_out_enable & dir_reg[DIR_SS]);

    assign serial_control_one  = ctrl_reg;
    assign port_direction_bits = dir_reg;
    assign serial_status_reg   = '{transfer_done_flag: done_reg, write_collision_flag: coll_reg,
                                   mode_fault_flag: fault_reg};
    assign serial_data_reg     = rx_reg;
    assign irq                 = irq_reg;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_collide;
        data_wr && busy && !sample_edge;
    endsequence

    property p_coll_set;
        data_wr && busy |=> coll_reg;
    endproperty
    a_coll_set: assert property (p_coll_set) else $error("collision flag not set");

    property p_discard;
        s_collide |=> shift_reg == $past(shift_reg);
    endproperty
    a_discard: assert property (p_discard) else $error("colliding write altered shifter");

    property p_coll_no_irq;
        !done_reg && !fault_reg |=> !irq;
    endproperty
    a_coll_no_irq: assert property (p_coll_no_irq) else $error("irq without done or fault");

    property p_fault;
        fault_det |=> fault_reg && !ctrl_reg.system_enable_bit && !ctrl_reg.master_select_bit
            && !dir_reg[DIR_SCK] && !dir_reg[DIR_MOSI];
    endproperty
    a_fault: assert property (p_fault) else $error("mode fault effects missing");

    property p_fault_irq;
        fault_reg && ctrl_reg.serial_irq_enable |=> irq;
    endproperty
    a_fault_irq: assert property (p_fault_irq) else $error("mode fault irq missing");

    property p_fault_off;
        dir_reg[DIR_SS] && !fault_reg |=> !fault_reg;
    endproperty
    a_fault_off: assert property (p_fault_off) else $error("fault with select as output");

    property p_bidir_keep;
        fault_det && ctrl_reg.bidir_mode |=> dir_reg[DIR_MISO] == $past(dir_reg[DIR_MISO]);
    endproperty
    a_bidir_keep: assert property (p_bidir_keep) else $error("slave pin direction lost");

    property p_freeze;
        low_power && active_reg && !ctrl_one_wr && !fault_det |=> $stable(edge_cnt_reg) && $stable(sck_out_reg);
    endproperty
    a_freeze: assert property (p_freeze) else $error("master moved in low power");

    property p_lp_noload;
        low_power |=> !$rose(done_reg) && $stable(rx_reg);
    endproperty
    a_lp_noload: assert property (p_lp_noload) else $error("load during low power");

    property p_done;
        last_edge && !low_power && !done_reg |=> done_reg ##1 done_reg || $past(done_clr);
    endproperty
    a_done: assert property (p_done) else $error("done flag not set after byte");

    property p_block;
        done_reg && !done_clr |=> $stable(rx_reg);
    endproperty
    a_block: assert property (p_block) else $error("data loaded over pending done");

    property p_holds;
        (done_reg && !data_access |=> done_reg) and (fault_reg && !ctrl_one_wr |=> fault_reg);
    endproperty
    a_holds: assert property (p_holds) else $error("flag cleared without sequence");

    property p_reset;
        @(posedge clk) disable iff (1'b0) reset |=> !done_reg && !fault_reg && rx_reg == DATA_RESET;
    endproperty
    a_reset: assert property (p_reset) else $error("reset state wrong");
endmodule : spfp_core

// ===== core/spfp_pkg.sv
/*
 * Shared constants and carrier types for the serial fault, power and flag logic.
 * Assumes a single 25 MHz system clock and an external baud enable pulse.
 */
package spfp_pkg;
    localparam int         DATA_W          = 8;
    localparam int         EDGES_PER_BYTE  = 16;
    localparam int         EDGE_CNT_W      = 5;
    localparam int         TAIL_GUARD_CLKS = 2;
    localparam int         DIR_MISO        = 0;
    localparam int         DIR_MOSI        = 1;
    localparam int         DIR_SCK         = 2;
    localparam int         DIR_SS          = 3;
    localparam logic [3:0] DIR_RESET       = 4'h0;
    localparam logic [7:0] DATA_RESET      = 8'h00;
    localparam logic [6:0] CTRL_ONE_RESET  = 7'h00;

    typedef struct packed {
        logic serial_irq_enable;
        logic system_enable_bit;
        logic master_select_bit;
        logic clk_polarity;
        logic clk_phase;
        logic ss_out_enable;
        logic bidir_mode;
    } spfp_ctrl_one_t;

    typedef struct packed {
        logic transfer_done_flag;
        logic write_collision_flag;
        logic mode_fault_flag;
    } spfp_status_t;

    typedef struct packed {
        logic sck;
        logic ss_n;
        logic mosi;
        logic miso;
    } spfp_pins_t;

    typedef struct packed {
        logic sck;
        logic sck_oe_n;
        logic mosi;
        logic mosi_oe_n;
        logic miso;
        logic miso_oe_n;
        logic ss_n;
        logic ss_oe_n;
    } spfp_pin_drive_t;
endpackage : spfp_pkg

// ===== core/spfp_sync.sv
/*
 * Two-flop synchroniser for a group of pin levels.
 * Assumes the inputs are levels from outside the clock domain.
 */
`timescale 1ns/1ps
module spfp_sync #(
    parameter int WIDTH = 4
) (
    input  wire logic             clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] din,
    output logic      [WIDTH-1:0] dout
);
    logic [WIDTH-1:0] stage_reg;

    // The first stage feeds only the second one.
    always_ff @(posedge clk) begin
        if (reset) begin
            stage_reg <= '0;
            dout      <= '0;
        end else begin
            stage_reg <= din;
            dout      <= stage_reg;
        end
    end
endmodule : spfp_sync

// ===== bench/spfp_far_end.sv
/*
 * Behavioural far end of the serial link: a slave that answers the block as master,
 * a master that drives the block as slave, and a second master that can pull select low.
 * Assumes clock polarity 0 and phase 0, and that the bench holds tx_byte stable during a frame.
 */
`timescale 1ns/1ps
module spfp_far_end (
    input  wire spfp_pkg::spfp_pin_drive_t drv,
    input  wire logic                      fault_low,
    input  wire logic                      go,
    input  wire logic [7:0]                tx_byte,
    output spfp_pkg::spfp_pins_t           pins,
    output logic [7:0]                     rx_byte,
    output logic                           busy
);
    import spfp_pkg::*;
    logic       m_sck  = 1'b0;
    logic       m_ss   = 1'b1;
    logic       m_mosi = 1'b0;
    logic       s_miso = 1'b0;
    logic [7:0] sh     = 8'h00;
    initial busy = 1'b0;
    // A second master pulling select low only happens when the bench commands it.
    assign pins.ss_n = fault_low ? 1'b0 : (!drv.ss_oe_n ? drv.ss_n : m_ss);
    assign pins.sck  = !drv.sck_oe_n ? drv.sck : m_sck;
    assign pins.mosi = !drv.mosi_oe_n ? drv.mosi : m_mosi;
    assign pins.miso = !drv.miso_oe_n ? drv.miso : s_miso;
    always @(negedge pins.ss_n) if (!busy) begin
        sh = tx_byte;
        s_miso = sh[7];
    end
    always @(posedge pins.sck) if (!busy) rx_byte = {rx_byte[6:0], pins.mosi};
    always @(negedge pins.sck) if (!busy) begin
        sh = sh << 1;
        s_miso = sh[7];
    end
    // A released data line must not keep its last level, so it flips.
    always @(posedge pins.ss_n) if (!busy) s_miso = ~s_miso;
    // Master role: the clock stands still low outside frames and select rises between bytes.
    always @(posedge go) begin
        busy = 1'b1;
        #13;
        sh = tx_byte;
        m_ss = 1'b0;
        m_mosi = sh[7];
        for (int i = 0; i < 8; i++) begin
            #160 m_sck = 1'b1;
            rx_byte = {rx_byte[6:0], pins.miso};
            #160 m_sck = 1'b0;
            sh = sh << 1;
            m_mosi = sh[7];
        end
        #160 m_ss = 1'b1;
        m_mosi = ~m_mosi;
        busy = 1'b0;
    end
endmodule : spfp_far_end

// ===== bench/tb_spi_fault_power_irq_logic.sv
/*
 * Self-checking bench for the serial fault, power and flag logic with a far-end model.
 * Assumes the block's core module and its package; the baud tick comes every fourth clock.
 */
`timescale 1ns/1ps
module tb_spi_fault_power_irq_logic;
    import spfp_pkg::*;
    logic            clk = 1'b0, reset = 1'b1, baud_tick = 1'b0, go = 1'b0, fault_low = 1'b0;
    logic            doze_mode = 1'b0, stop_mode = 1'b0, doze_stop_bit = 1'b0;
    logic            ctrl_one_wr = 1'b0, dir_wr = 1'b0, data_wr = 1'b0, data_rd = 1'b0, status_rd = 1'b0;
    spfp_ctrl_one_t  ctrl_one_wdata = '0;
    logic [3:0]      dir_wdata = 4'h0;
    logic [7:0]      data_wdata = 8'h00, tx_byte = 8'h00, rx_byte, serial_data_reg, b0, b1;
    spfp_pins_t      pins_in;
    spfp_pin_drive_t pin_drive;
    spfp_ctrl_one_t  serial_control_one;
    spfp_status_t    serial_status_reg;
    logic [3:0]      port_direction_bits;
    logic            irq, busy;
    int              fail_count = 0, n_checks = 0, seed = 88, cycles = 0, tick_cnt = 0;

    spfp_core spfp_core_inst (.clk, .reset, .baud_tick, .doze_mode, .stop_mode, .doze_stop_bit,
        .ctrl_one_wr, .ctrl_one_wdata, .dir_wr, .dir_wdata, .data_wr, .data_wdata, .data_rd,
        .status_rd, .pins_in, .pin_drive, .serial_control_one, .port_direction_bits,
        .serial_status_reg, .serial_data_reg, .irq);
    spfp_far_end spfp_far_end_inst (.drv(pin_drive), .fault_low, .go, .tx_byte, .pins(pins_in),
        .rx_byte, .busy);

    initial forever #20 clk = ~clk;
    always @(posedge clk) begin
        tick_cnt <= (tick_cnt + 1) % 4;
        baud_tick <= (tick_cnt == 3);
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            fail_count = fail_count + 1;
            tally_and_finish();
        end
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : check

    // Kinds: 0 control one, 1 directions, 2 data write, 3 data read, 4 status read.
    task automatic cpu(input int kind, input logic [7:0] v);
        @(posedge clk);
        ctrl_one_wr <= (kind == 0);
        dir_wr <= (kind == 1);
        data_wr <= (kind == 2);
        data_rd <= (kind == 3);
        status_rd <= (kind == 4);
        ctrl_one_wdata <= v[6:0];
        dir_wdata <= v[3:0];
        data_wdata <= v;
        @(posedge clk);
        {ctrl_one_wr, dir_wr, data_wr, data_rd, status_rd} <= 5'h00;
    endtask : cpu

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : settle

    task automatic wait_done();
        int i;
        i = 0;
        while (serial_status_reg.transfer_done_flag !== 1'b1 && i < 3000) begin
            @(posedge clk);
            i++;
        end
        #1;
    endtask : wait_done

    task automatic clear_flags();
        cpu(4, 8'h00);
        cpu(3, 8'h00);
        settle(2);
    endtask : clear_flags

    task automatic tally_and_finish();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        settle(3);
        check({1'b0, serial_control_one}, 8'h00);
        check({5'h00, serial_status_reg}, 8'h00);
        check({4'h0, port_direction_bits}, 8'h00);
        check(serial_data_reg, 8'h00);
        check({7'h00, irq}, 8'h00);
        // Master with automatic select; the far end answers as slave.
        cpu(1, 8'h0E);
        cpu(0, 8'h72);
        b0 = $random(seed);
        b1 = $random(seed);
        tx_byte <= b1;
        cpu(2, b0);
        settle(8);
        cpu(2, ~b0);
        settle(2);
        check({7'h00, serial_status_reg.write_collision_flag}, 8'h01);
        check({7'h00, irq}, 8'h00);
        wait_done();
        settle(2);
        check(serial_data_reg, b1);
        check(rx_byte, b0);
        check({7'h00, irq}, 8'h01);
        // A second byte while the done flag is still set must not reach the data register.
        tx_byte <= ~b1;
        cpu(2, b0);
        settle(100);
        check(serial_data_reg, b1);
        cpu(3, 8'h00);
        settle(1);
        check({7'h00, serial_status_reg.transfer_done_flag}, 8'h01);
        clear_flags();
        check({5'h00, serial_status_reg}, 8'h00);
        check({7'h00, irq}, 8'h00);
        // Doze without doze-stop runs on; doze-stop and stop freeze, then resume.
        for (int m = 0; m < 3; m++) begin
            b0 = $random(seed);
            tx_byte <= b0;
            cpu(2, b0 ^ 8'h5A);
            settle(20);
            doze_mode <= (m != 2);
            stop_mode <= (m == 2);
            doze_stop_bit <= (m == 1);
            settle(200);
            check({7'h00, serial_status_reg.transfer_done_flag}, (m == 0) ? 8'h01 : 8'h00);
            {doze_mode, stop_mode, doze_stop_bit} <= 3'h0;
            wait_done();
            check(serial_data_reg, b0);
            check(rx_byte, b0 ^ 8'h5A);
            clear_flags();
        end
        // Slave, phase 0, with the far end as master.
        cpu(1, 8'h01);
        cpu(0, 8'h20);
        b0 = $random(seed);
        b1 = $random(seed);
        cpu(2, b1);
        tx_byte <= b0;
        go <= 1'b1;
        settle(30);
        cpu(2, 8'hA5);
        settle(2);
        check({7'h00, serial_status_reg.write_collision_flag}, 8'h01);
        wait_done();
        check(serial_data_reg, b0);
        go <= 1'b0;
        settle(60);
        check(rx_byte, b1);
        clear_flags();
        // In stop mode the slave may shift but loads nothing and sets no flag.
        stop_mode <= 1'b1;
        tx_byte <= ~b0;
        go <= 1'b1;
        settle(90);
        check({7'h00, serial_status_reg.transfer_done_flag}, 8'h00);
        check(serial_data_reg, b0);
        // The slave still shifts out the byte it last received.
        check(rx_byte, b0);
        stop_mode <= 1'b0;
        go <= 1'b0;
        // Slave, phase 1, select held low past the byte; link data is not checked here.
        cpu(0, 8'h24);
        fault_low <= 1'b1;
        go <= 1'b1;
        while (serial_status_reg.transfer_done_flag !== 1'b1) @(posedge clk);
        data_wr <= 1'b1;
        data_wdata <= 8'h3C;
        @(posedge clk);
        data_wr <= 1'b0;
        settle(1);
        check({7'h00, serial_status_reg.write_collision_flag}, 8'h01);
        clear_flags();
        cpu(2, 8'hC3);
        settle(1);
        check({7'h00, serial_status_reg.write_collision_flag}, 8'h00);
        fault_low <= 1'b0;
        go <= 1'b0;
        // Mode fault with select as an input, in normal and bidirectional mode.
        for (int b = 0; b < 2; b++) begin
            cpu(1, 8'h07);
            cpu(0, b ? 8'h71 : 8'h70);
            fault_low <= 1'b1;
            settle(6);
            fault_low <= 1'b0;
            check({7'h00, serial_status_reg.mode_fault_flag}, 8'h01);
            check({7'h00, irq}, 8'h01);
            check({1'b0, serial_control_one}, b ? 8'h41 : 8'h40);
            check({4'h0, port_direction_bits}, b ? 8'h01 : 8'h00);
            cpu(0, 8'h48);
            settle(1);
            check({7'h00, serial_status_reg.mode_fault_flag}, 8'h01);
            check({1'b0, serial_control_one}, 8'h48);
            cpu(4, 8'h00);
            cpu(0, 8'h40);
            settle(2);
            check({7'h00, serial_status_reg.mode_fault_flag}, 8'h00);
            check({7'h00, irq}, 8'h00);
        end
        // Select configured as automatic output: a low level is no fault.
        cpu(1, 8'h0E);
        cpu(0, 8'h72);
        fault_low <= 1'b1;
        settle(6);
        fault_low <= 1'b0;
        check({7'h00, serial_status_reg.mode_fault_flag}, 8'h00);
        check({1'b0, serial_control_one}, 8'h72);
        // Reset in mid-run while a flag and the interrupt are raised.
        cpu(1, 8'h07);
        fault_low <= 1'b1;
        settle(6);
        check({7'h00, serial_status_reg.mode_fault_flag}, 8'h01);
        check({7'h00, irq}, 8'h01);
        reset <= 1'b1;
        fault_low <= 1'b0;
        settle(4);
        reset <= 1'b0;
        settle(3);
        check({5'h00, serial_status_reg}, 8'h00);
        check({1'b0, serial_control_one}, 8'h00);
        check({4'h0, port_direction_bits}, 8'h00);
        check(serial_data_reg, 8'h00);
        check({7'h00, irq}, 8'h00);
        tally_and_finish();
    end
endmodule : tb_spi_fault_power_irq_logic
